// File: hdl/rsd_status_mux.v
// radio status registers, debug output multiplexer and event interrupt
//
// Functional notes
// - signal strength register reads the full 8-bit strength value.
// - state register bits 4:0 give state code, bits 7:5 read zero.
// - codes 0x0D..0x16: receive, switches, overflow, transmit, underflow.
// - packet status bits 7..3 hold crc, carrier, preamble, clear, delimiter.
// - crc pass set on match, cleared on entering or restarting receive.
// - 8-bit read-only oscillator calibration value for test use.
// - each debug pin routes a signal chosen by a 6-bit selector.
// - selector 8 drives preamble quality reached.
// - selector 9 drives clear channel, per configured mode.
// - selector 11 drives serial clock; data changes on its falling edge.
// - selector 13 drives received data transparently, no clock.
// - selector 14 drives carrier sense.
// - selector 15 drives the crc pass flag.
// - selector 16 serial i/q samples; 17 filter and gain signals.
// - selector 47 drives low; inversion gives constant high.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "rsd_consts.vh"

module rsd_status_mux #(
    parameter ADDR_W = 16,
    parameter NUM_OUT = 3
) (
    input  wire         clock_i,
    input  wire         sys_rst_i,
    // register port
    input  wire [ADDR_W-1:0] addr_i,
    input  wire [7:0]   wdata_i,
    input  wire         wr_i,
    input  wire         rd_i,
    output reg  [7:0]   rdata_o,
    // radio core status
    input  wire [7:0]   signal_strength_i,
    input  wire [4:0]   fsm_state_code_i,
    input  wire [7:0]   osc_cal_test_value_i,
    input  wire         crc_check_done_i,
    input  wire         crc_match_i,
    input  wire         carrier_sense_i,
    input  wire         preamble_quality_reached_i,
    input  wire         clear_channel_i,
    input  wire         frame_delimiter_found_i,
    input  wire         lock_detect_i,
    input  wire         serial_clk_en_i,
    input  wire         serial_data_i,
    input  wire         async_data_i,
    input  wire         adc_iq_serial_i,
    input  wire         demod_debug_i,
    // debug pins and interrupt
    output reg  [2:0]   debug_out_o,
    output reg          irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // selector decode, shared by all outputs
    function sel_value;
        input [5:0] sel;
        input [13:0] sig;
        begin
            case (sel)
                `RSD_SEL_PQT:    sel_value = sig[0];
                `RSD_SEL_CCA:    sel_value = sig[1];
                `RSD_SEL_LOCK:   sel_value = sig[2];
                `RSD_SEL_SCLK:   sel_value = sig[3];
                `RSD_SEL_SDATA:  sel_value = sig[4];
                `RSD_SEL_ADATA:  sel_value = sig[5];
                `RSD_SEL_CS:     sel_value = sig[6];
                `RSD_SEL_CRC:    sel_value = sig[7];
                `RSD_SEL_ADC_IQ: sel_value = sig[8];
                `RSD_SEL_DEMOD:  sel_value = sig[9];
                `RSD_SEL_ZERO:   sel_value = 1'b0;
                default:         sel_value = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state and flags
    reg [7:0] cfg [0:2];
    reg       crc_ok;
    reg [7:0] pkt_status;
    reg [3:0] irq_status;
    reg [3:0] irq_mask;
    reg [4:0] prev_state;
    reg       prev_sfd;
    reg       serial_clk;
    reg       serial_data;
    reg       serial_data_pending;

    wire enter_rx;
    wire [3:0] events;
    wire [13:0] sigs;
    wire [2:0] next_debug_out;

    // entering rx or passing through the restart state clears crc pass
    assign enter_rx = ((fsm_state_code_i == `RSD_ST_RX) &&
                       (prev_state != `RSD_ST_RX)) ||
                      (fsm_state_code_i == `RSD_ST_RX_RST);

    // hardware events for the sticky status register
    assign events = {(fsm_state_code_i == `RSD_ST_TX_UNF) &&
                     (prev_state != `RSD_ST_TX_UNF),
                     (fsm_state_code_i == `RSD_ST_RX_OVF) &&
                     (prev_state != `RSD_ST_RX_OVF),
                     frame_delimiter_found_i & ~prev_sfd,
                     crc_check_done_i & crc_match_i};

    assign sigs = {4'h0, demod_debug_i, adc_iq_serial_i, crc_ok,
                   carrier_sense_i, async_data_i, serial_data, serial_clk,
                   lock_detect_i, clear_channel_i,
                   preamble_quality_reached_i};

    ////////////////////////////////////////////////////////////////////////
    // crc flag and edge history
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            crc_ok     <= 1'b0;
            prev_state <= 5'h00;
            prev_sfd   <= 1'b0;
        end else begin
            prev_state <= fsm_state_code_i;
            prev_sfd   <= frame_delimiter_found_i;
            if (enter_rx)
                crc_ok <= 1'b0;
            else if (crc_check_done_i)
                crc_ok <= crc_match_i;
        end
    end

    // packet status snapshot, low bits stay zero
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            pkt_status <= 8'h00;
        end else begin
            pkt_status <= {crc_ok, carrier_sense_i,
                           preamble_quality_reached_i, clear_channel_i,
                           frame_delimiter_found_i, 3'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial clock: data launched at the enable, clock falls there too,
    // rises one cycle later, so data is stable at every rising edge
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            serial_clk          <= 1'b0;
            serial_data         <= 1'b0;
            serial_data_pending <= 1'b0;
        end else if (serial_clk_en_i) begin
            serial_clk          <= 1'b0;
            serial_data         <= serial_data_i;
            serial_data_pending <= 1'b1;
        end else if (serial_data_pending) begin
            serial_clk          <= 1'b1;
            serial_data_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers and sticky interrupt status; set wins over clear
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            cfg[0]     <= `RSD_CFG_RESET;
            cfg[1]     <= `RSD_CFG_RESET;
            cfg[2]     <= `RSD_CFG_RESET;
            irq_status <= 4'h0;
            irq_mask   <= 4'h0;
        end else begin
            if (wr_i && addr_i == `RSD_ADDR_DEBUG_OUT0_CFG)
                cfg[0] <= {1'b0, wdata_i[6:0]};
            if (wr_i && addr_i == `RSD_ADDR_DEBUG_OUT1_CFG)
                cfg[1] <= {1'b0, wdata_i[6:0]};
            if (wr_i && addr_i == `RSD_ADDR_DEBUG_OUT2_CFG)
                cfg[2] <= {1'b0, wdata_i[6:0]};
            if (wr_i && addr_i == `RSD_ADDR_IRQ_MASK)
                irq_mask <= wdata_i[3:0];
            if (wr_i && addr_i == `RSD_ADDR_IRQ_STATUS)
                irq_status <= (irq_status & ~wdata_i[3:0]) | events;
            else
                irq_status <= irq_status | events;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debug outputs, one mux per pin, polarity applied last; the pins are
    // registered in one process so the vector keeps a single driver
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1) begin : gen_out
            assign next_debug_out[g] = sel_value(cfg[g][5:0], sigs) ^
                                       cfg[g][`RSD_CFG_INV];
        end
    endgenerate

    // debug pin register
    always @(posedge clock_i) begin
        if (sys_rst_i)
            debug_out_o <= 3'h0;
        else
            debug_out_o <= next_debug_out;
    end

    // interrupt level from registered status and mask
    always @(posedge clock_i) begin
        if (sys_rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_status & irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data in the cycle after the strobe; unmapped reads zero
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `RSD_ADDR_SIGNAL_STRENGTH:
                    rdata_o <= signal_strength_i;
                `RSD_ADDR_RADIO_FSM_STATE:
                    rdata_o <= {3'h0, fsm_state_code_i};
                `RSD_ADDR_PACKET_STATUS:   rdata_o <= pkt_status;
                `RSD_ADDR_OSC_CAL_TEST:
                    rdata_o <= osc_cal_test_value_i;
                `RSD_ADDR_DEBUG_OUT0_CFG: rdata_o <= cfg[0];
                `RSD_ADDR_DEBUG_OUT1_CFG: rdata_o <= cfg[1];
                `RSD_ADDR_DEBUG_OUT2_CFG: rdata_o <= cfg[2];
                `RSD_ADDR_IRQ_STATUS:     rdata_o <= {4'h0, irq_status};
                `RSD_ADDR_IRQ_MASK:       rdata_o <= {4'h0, irq_mask};
                default:                  rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// File: hdl/rsd_consts.vh
// constants for the radio status registers and debug output multiplexer
`ifndef RSD_CONSTS_VH
`define RSD_CONSTS_VH

// register offsets on the radio register space
`define RSD_ADDR_SIGNAL_STRENGTH  16'hDF3A
`define RSD_ADDR_RADIO_FSM_STATE  16'hDF3B
`define RSD_ADDR_PACKET_STATUS    16'hDF3C
`define RSD_ADDR_OSC_CAL_TEST     16'hDF3D
// registers of this block's own
`define RSD_ADDR_DEBUG_OUT0_CFG   16'hDF40
`define RSD_ADDR_DEBUG_OUT1_CFG   16'hDF41
`define RSD_ADDR_DEBUG_OUT2_CFG   16'hDF42
`define RSD_ADDR_IRQ_STATUS       16'hDF43
`define RSD_ADDR_IRQ_MASK         16'hDF44

// packet status bit positions
`define RSD_PKT_CRC_OK   7
`define RSD_PKT_CS       6
`define RSD_PKT_PQT      5
`define RSD_PKT_CCA      4
`define RSD_PKT_SFD      3

// debug config fields: selector in 5:0, inversion in 6
`define RSD_CFG_INV      6
`define RSD_CFG_RESET    8'h2F

// selector codes
`define RSD_SEL_PQT      6'h08
`define RSD_SEL_CCA      6'h09
`define RSD_SEL_LOCK     6'h0A
`define RSD_SEL_SCLK     6'h0B
`define RSD_SEL_SDATA    6'h0C
`define RSD_SEL_ADATA    6'h0D
`define RSD_SEL_CS       6'h0E
`define RSD_SEL_CRC      6'h0F
`define RSD_SEL_ADC_IQ   6'h10
`define RSD_SEL_DEMOD    6'h11
`define RSD_SEL_ZERO     6'h2F

// state codes
`define RSD_ST_RX        5'h0D
`define RSD_ST_RX_RST    5'h0F
`define RSD_ST_RX_OVF    5'h11
`define RSD_ST_TX_UNF    5'h16
`define RSD_ST_MAX       5'h16

// interrupt status bits
`define RSD_IRQ_CRC      0
`define RSD_IRQ_SFD      1
`define RSD_IRQ_OVF      2
`define RSD_IRQ_UNF      3

`endif

// File: bench/rsd_status_mux_sva.sv
// assertion checker watching the radio status mux ports
`timescale 1ns/100ps
`default_nettype none
module rsd_status_mux_sva (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [7:0]  signal_strength_i,
    input wire logic [4:0]  fsm_state_code_i,
    input wire logic        preamble_quality_reached_i,
    input wire logic        serial_clk_en_i,
    input wire logic [2:0]  debug_out_o,
    input wire logic        irq_o
);
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] cfg0;
    logic       cfg_seen;
    ////////////////////////////////////////////////////////////////////////
    // shadow of output 0 config, since the selector itself is not visible
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            cfg0     <= 8'h2F;
            cfg_seen <= 1'b0;
        end else if (wr_i && addr_i >= 16'hDF40 && addr_i <= 16'hDF42) begin
            cfg_seen <= 1'b1;
            if (addr_i == 16'hDF40)
                cfg0 <= wdata_i;
        end
    end
    // serial clock pin: low then high after each new bit
    sequence s_sclk_rise;
        !debug_out_o[0] ##1 debug_out_o[0];
    endsequence
    // reset must not be masked here, it is the cause being checked
    property p_rst;
        disable iff (1'b0) $fell(sys_rst_i) |->
            rdata_o == 8'h00 && debug_out_o == 3'h0 && !irq_o;
    endproperty
    property p_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    property p_signal_strength;
        rd_i && addr_i == 16'hDF3A |=> rdata_o == $past(signal_strength_i);
    endproperty
    property p_state;
        rd_i && addr_i == 16'hDF3B |=>
            rdata_o == {3'h0, $past(fsm_state_code_i)};
    endproperty
    property p_unmap;
        rd_i && (addr_i < 16'hDF3A || addr_i > 16'hDF44) |=> rdata_o == 8'h00;
    endproperty
    property p_dflt;
        !cfg_seen |-> debug_out_o == 3'h0;
    endproperty
    property p_pqt;
        cfg0 == 8'h08 |=> debug_out_o[0] == $past(preamble_quality_reached_i);
    endproperty
    property p_sclk;
        serial_clk_en_i && cfg0 == 8'h0B ##1 cfg0 == 8'h0B |=> s_sclk_rise;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear");
    a_idle: assert property (p_idle) else $error("read data lingers");
    a_signal_strength: assert property (p_signal_strength) else $error("bad strength");
    a_state: assert property (p_state) else $error("bad state");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_dflt: assert property (p_dflt) else $error("pin not low");
    a_pqt: assert property (p_pqt) else $error("preamble pin");
    a_sclk: assert property (p_sclk) else $error("serial clock");
endmodule
`default_nettype wire

// File: bench/rsd_serial_sink.sv
// far-side logic that shifts in synchronous serial debug data
`timescale 1ns/100ps
`default_nettype none
module rsd_serial_sink (
    input  wire logic       sclk_i,
    input  wire logic       sdata_i,
    output var  logic [7:0] byte_o
);
    // data is set up on the falling edge, so take it on the rising one
    initial byte_o = 8'h00;
    always @(posedge sclk_i) begin
        byte_o <= {byte_o[6:0], sdata_i};
    end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the radio status mux
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clock_i = 1'b0, sys_rst_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00, signal_strength_i = 8'hA5;
    logic        wr_i = 1'b0, rd_i = 1'b0, serial_clk_en_i = 1'b0;
    logic [4:0]  fsm_state_code_i = 5'h01;
    logic [7:0]  osc_cal_test_value_i = 8'h3C, tx_byte = 8'hB4;
    logic        crc_check_done_i = 1'b0, crc_match_i = 1'b0;
    logic        carrier_sense_i = 1'b0, preamble_quality_reached_i = 1'b0;
    logic        clear_channel_i = 1'b0, frame_delimiter_found_i = 1'b0;
    logic        lock_detect_i = 1'b0, serial_data_i = 1'b0;
    logic        async_data_i = 1'b0, adc_iq_serial_i = 1'b0;
    logic        demod_debug_i = 1'b0;
    wire  [7:0]  rdata_o, rx_byte;
    wire  [2:0]  debug_out_o;
    wire         irq_o;
    int          err_count = 0, samples_checked = 0, i;
    // selectors: first eight follow their source, the rest are tied low
    logic [5:0]  codes [12] = '{6'h08, 6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h0F,
                                6'h10, 6'h11, 6'h00, 6'h07, 6'h15, 6'h2F};
    always #2.5 clock_i = ~clock_i;
    rsd_status_mux u_rsd_status_mux (.*);
    rsd_serial_sink u_rsd_serial_sink (
        .sclk_i  (debug_out_o[0]),
        .sdata_i (debug_out_o[1]),
        .byte_o  (rx_byte)
    );
    ////////////////////////////////////////////////////////////////////////
    // shared compare, register access and pin tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task automatic pin(input int p, input logic e);
        repeat (2) @(posedge clock_i);
        #1 chk({7'h00, debug_out_o[p]}, {7'h00, e});
    endtask
    task automatic set_src(input logic v);
        @(posedge clock_i);
        {carrier_sense_i, preamble_quality_reached_i} <= {2{v}};
        clear_channel_i <= v;
        {frame_delimiter_found_i, lock_detect_i, async_data_i} <= {3{v}};
        {adc_iq_serial_i, demod_debug_i} <= {2{v}};
    endtask
    // walk the selector table over the three pins, then inversion
    task automatic pass(input logic v);
        int k;
        for (k = 0; k < 12; k++) begin
            wr(16'hDF40 + 16'(k % 3), {2'h0, codes[k]});
            if (k < 8)
                pin(k % 3, v);
            else
                pin(k % 3, 1'b0);
        end
        wr(16'hDF41, 8'h6F);
        pin(1, 1'b1);
        wr(16'hDF42, 8'h48);
        pin(2, ~v);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 3; i++) rd(16'hDF40 + 16'(i), 8'h2F);
        chk({5'h00, debug_out_o}, 8'h00);
        rd(16'hDF3A, 8'hA5);
        rd(16'hDF3D, 8'h3C);
        for (i = 0; i < 23; i++) begin
            @(posedge clock_i);
            fsm_state_code_i <= 5'(i);
            rd(16'hDF3B, {3'h0, 5'(i)});
        end
        rd(16'hDF45, 8'h00);
        wr(16'hDF3A, 8'h00);
        rd(16'hDF3A, 8'hA5);
        set_src(1'b1);
        // one finished compare that matched
        @(posedge clock_i);
        {crc_check_done_i, crc_match_i} <= 2'h3;
        @(posedge clock_i);
        crc_check_done_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rd(16'hDF3C, 8'hF8);
        rd(16'hDF43, 8'h0F);
        chk({7'h00, irq_o}, 8'h00);
        pass(1'b1);
        wr(16'hDF44, 8'h04);
        repeat (2) @(posedge clock_i);
        #1 chk({7'h00, irq_o}, 8'h01);
        wr(16'hDF43, 8'h0F);
        rd(16'hDF43, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        // entering receive drops the match flag
        set_src(1'b0);
        @(posedge clock_i);
        fsm_state_code_i <= 5'h0D;
        repeat (3) @(posedge clock_i);
        rd(16'hDF3C, 8'h00);
        pass(1'b0);
        // one byte over the synchronous serial pins, msb first
        wr(16'hDF41, 8'h0C);
        wr(16'hDF40, 8'h0B);
        for (i = 7; i >= 0; i--) begin
            @(posedge clock_i);
            {serial_clk_en_i, serial_data_i} <= {1'b1, tx_byte[i]};
            @(posedge clock_i);
            serial_clk_en_i <= 1'b0;
            repeat (4) @(posedge clock_i);
        end
        chk(rx_byte, 8'hB4);
        report_and_stop();
    end
endmodule
bind rsd_status_mux rsd_status_mux_sva u_rsd_status_mux_sva (.*);
`default_nettype wire
